/* common/gpw_pkg.sv */
// Constants, types and helpers shared by the general purpose port block
// Notes on behaviour
// - Port logic drives and samples all free pins
// - Each pin direction set by own bit
// - Set and clear registers change many outputs
// - Read back output latch and live pin level
// - Mask bits keep value during port writes
// - Byte, halfword and word accesses all supported
// - Whole port output written in one access
// - Ports 0 and 2 give rise/fall edge interrupts
// - Edge seen without clock through raw pin
// - Enabled edge raises a power-down wake request
// - After reset all pins are inputs
// - Registers sit on fast zero-wait system port
// - DMA engine uses the same register port
package gpw_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_PORTS = 3;    // Ports 0, 1 and 2
  localparam int PORT_W = 32;      // Pins per port
  localparam int ADDR_W = 8;       // Byte address width
  localparam int BE_W = 4;         // Byte enables per word

  // ----------------------------------------------------------------------
  // Port register window: port p sits at p * 0x20
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFS_DIR = 5'h00;    // Direction, 1 = output
  localparam logic [4:0] OFS_MASK = 5'h04;   // Write/read mask, 1 = excluded
  localparam logic [4:0] OFS_PIN = 5'h08;    // Read live pins, write whole port
  localparam logic [4:0] OFS_SET = 5'h0C;    // Write ones to drive high
  localparam logic [4:0] OFS_CLR = 5'h10;    // Write ones to drive low
  localparam logic [4:0] OFS_OUT = 5'h14;    // Read output latch

  // ----------------------------------------------------------------------
  // Edge interrupt windows for port 0 and port 2
  // ----------------------------------------------------------------------
  localparam logic [7:0] EDGE0_BASE = 8'h60;  // Port 0 edge registers
  localparam logic [7:0] EDGE2_BASE = 8'h70;  // Port 2 edge registers
  localparam logic [3:0] OFS_RISE = 4'h0;     // Rising edge enable
  localparam logic [3:0] OFS_FALL = 4'h4;     // Falling edge enable
  localparam logic [3:0] OFS_STAT = 4'h8;     // Sticky status, write one clears
  localparam logic [3:0] OFS_IMSK = 4'hC;     // Interrupt mask, 1 = enabled

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;  // Every register clears
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;  // Unmapped reads

  // Expand byte enables into a bit mask
  function automatic logic [31:0] be_bits(input logic [3:0] be);
    be_bits = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge new data into old data on the enabled byte lanes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    be_merge = (old_v & ~be_bits(be)) | (new_v & be_bits(be));
  endfunction

endpackage

/* hw/gpw_edge.sv */
// Edge interrupt detector and wake logic for one port
module gpw_edge (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_pin_sync,
  input wire logic [31:0] i_pin_raw,
  input wire logic i_wr,
  input wire logic [3:0] i_ofs,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_be,
  output logic [31:0] o_rise_en,
  output logic [31:0] o_fall_en,
  output logic [31:0] o_stat,
  output logic [31:0] o_imsk,
  output logic o_irq,
  output logic o_wake
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rise_en;  // Rising edge enables
    logic [31:0] fall_en;  // Falling edge enables
    logic [31:0] imsk;     // Interrupt mask
    logic [31:0] stat;     // Sticky edge status
    logic [31:0] prev;     // Last synchronised level
  } gpw_edge_st_type;

  gpw_edge_st_type st;
  gpw_edge_st_type next_st;
  logic [31:0] events;     // Edges seen this cycle
  logic [31:0] clr_bits;   // Status bits written with one

  // Edge detection and register updates
  always_comb begin
    next_st = st;
    events = (st.rise_en & i_pin_sync & ~st.prev) |
             (st.fall_en & ~i_pin_sync & st.prev);
    clr_bits = '0;
    if (i_wr) begin
      unique case (i_ofs)
        gpw_pkg::OFS_RISE: next_st.rise_en = gpw_pkg::be_merge(st.rise_en, i_wdata, i_be);
        gpw_pkg::OFS_FALL: next_st.fall_en = gpw_pkg::be_merge(st.fall_en, i_wdata, i_be);
        gpw_pkg::OFS_IMSK: next_st.imsk = gpw_pkg::be_merge(st.imsk, i_wdata, i_be);
        gpw_pkg::OFS_STAT: clr_bits = i_wdata & gpw_pkg::be_bits(i_be);
        default: clr_bits = '0;
      endcase
    end
    // New edge wins over a clear in the same cycle
    next_st.stat = (st.stat & ~clr_bits) | events;
    next_st.prev = i_pin_sync;
  end

  // Register the state
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign o_rise_en = st.rise_en;
  assign o_fall_en = st.fall_en;
  assign o_stat = st.stat;
  assign o_imsk = st.imsk;
  assign o_irq = |(st.stat & st.imsk);
  // Raw pin against last sample needs no clock edge, so a stopped clock still wakes
  assign o_wake = o_irq | |((st.rise_en & i_pin_raw & ~st.prev) |
                            (st.fall_en & ~i_pin_raw & st.prev));

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_rise_sets_stat: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.rise_en[0] && i_pin_sync[0] && !st.prev[0]) |=> st.stat[0])
    else $error("rising edge did not set status");
  a_stat_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.stat[0] && !(i_wr && i_ofs == gpw_pkg::OFS_STAT)) |=> st.stat[0])
    else $error("status bit dropped without clear");
  a_wake_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.stat[0] && st.imsk[0] && !i_wr) |=> (o_wake && o_irq))
    else $error("pending edge gave no wake");

endmodule

/* hw/gpw_port.sv */
// General purpose parallel port block with edge wake-up
module gpw_port (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port, shared by processor and DMA engine
  input wire logic [gpw_pkg::ADDR_W-1:0] i_bus_addr,
  input wire logic [31:0] i_bus_wdata,
  input wire logic [gpw_pkg::BE_W-1:0] i_bus_be,
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  output logic [31:0] o_bus_rdata,
  // Pins
  input wire logic [gpw_pkg::NUM_PORTS-1:0][31:0] i_gpio_in,
  output logic [gpw_pkg::NUM_PORTS-1:0][31:0] o_gpio_out,
  output logic [gpw_pkg::NUM_PORTS-1:0][31:0] o_gpio_oe,
  // Events
  output logic o_irq,
  output logic o_wake
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [gpw_pkg::NUM_PORTS-1:0][31:0] sync1;  // First synchroniser stage
    logic [gpw_pkg::NUM_PORTS-1:0][31:0] sync2;  // Second synchroniser stage
    logic [gpw_pkg::NUM_PORTS-1:0][31:0] dir;    // Direction bits
    logic [gpw_pkg::NUM_PORTS-1:0][31:0] mask;   // Mask bits
    logic [gpw_pkg::NUM_PORTS-1:0][31:0] out;    // Output latch
    logic [31:0] rdata;                          // Read data, one cycle
  } gpw_port_st_type;

  gpw_port_st_type st;
  gpw_port_st_type next_st;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  logic [gpw_pkg::NUM_PORTS-1:0] port_hit;  // Access falls in a port window
  logic [4:0] port_ofs;                     // Offset inside a port window
  logic edge0_hit;                          // Port 0 edge window
  logic edge2_hit;                          // Port 2 edge window
  logic [31:0] lane_bits;                   // Enabled byte lanes as bits
  logic [3:0] edge_ofs;                     // Offset inside an edge window

  // Edge unit outputs
  logic [31:0] e0_rise;
  logic [31:0] e0_fall;
  logic [31:0] e0_stat;
  logic [31:0] e0_imsk;
  logic e0_irq;
  logic e0_wake;
  logic [31:0] e2_rise;
  logic [31:0] e2_fall;
  logic [31:0] e2_stat;
  logic [31:0] e2_imsk;
  logic e2_irq;
  logic e2_wake;

  // Decode the byte address into windows
  always_comb begin
    // Bits 1:0 are dropped and the byte enables pick the lanes, so offsets are word aligned
    port_ofs = {i_bus_addr[4:2], 2'b00};
    edge_ofs = {i_bus_addr[3:2], 2'b00};
    for (int p = 0; p < gpw_pkg::NUM_PORTS; p++) begin
      // Each port owns a 0x20 byte window
      port_hit[p] = (i_bus_addr[7:5] == 3'(p));
    end
    edge0_hit = (i_bus_addr[7:4] == gpw_pkg::EDGE0_BASE[7:4]);
    edge2_hit = (i_bus_addr[7:4] == gpw_pkg::EDGE2_BASE[7:4]);
    lane_bits = gpw_pkg::be_bits(i_bus_be);
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Synchronisers, port writes and read capture
  always_comb begin
    logic [31:0] open_bits;  // Bits that a port write may touch
    open_bits = '0;
    next_st = st;
    // Two flop synchroniser on every pin
    next_st.sync1 = i_gpio_in;
    next_st.sync2 = st.sync1;
    // Read data stand for one cycle only
    next_st.rdata = '0;

    for (int p = 0; p < gpw_pkg::NUM_PORTS; p++) begin
      // Mask and byte lanes together gate the output latch
      open_bits = lane_bits & ~st.mask[p];
      if (i_bus_wr && port_hit[p]) begin
        case (port_ofs)
          // Direction bits, any number at any time
          gpw_pkg::OFS_DIR: begin
            next_st.dir[p] = gpw_pkg::be_merge(st.dir[p], i_bus_wdata, i_bus_be);
          end
          // Mask register itself is not masked
          gpw_pkg::OFS_MASK: begin
            next_st.mask[p] = gpw_pkg::be_merge(st.mask[p], i_bus_wdata, i_bus_be);
          end
          // Whole port value in one access, masked bits kept
          gpw_pkg::OFS_PIN, gpw_pkg::OFS_OUT: begin
            next_st.out[p] = (st.out[p] & ~open_bits) | (i_bus_wdata & open_bits);
          end
          // Ones drive high, zeros leave alone
          gpw_pkg::OFS_SET: begin
            next_st.out[p] = st.out[p] | (i_bus_wdata & open_bits);
          end
          // Ones drive low, zeros leave alone
          gpw_pkg::OFS_CLR: begin
            next_st.out[p] = st.out[p] & ~(i_bus_wdata & open_bits);
          end
          // Unmapped offsets ignore writes
          default: begin
            next_st.out[p] = st.out[p];
          end
        endcase
      end
      if (i_bus_rd && port_hit[p]) begin
        case (port_ofs)
          // Direction readback
          gpw_pkg::OFS_DIR: next_st.rdata = st.dir[p];
          // Mask readback
          gpw_pkg::OFS_MASK: next_st.rdata = st.mask[p];
          // Live synchronised pins, masked bits read as zero
          gpw_pkg::OFS_PIN: next_st.rdata = st.sync2[p] & ~st.mask[p];
          // Stored output latch
          gpw_pkg::OFS_OUT: next_st.rdata = st.out[p];
          // Set, clear and holes read as zero
          default: next_st.rdata = gpw_pkg::RD_UNMAPPED;
        endcase
      end
    end

    // Edge unit registers
    if (i_bus_rd && edge0_hit) begin
      case (edge_ofs)
        gpw_pkg::OFS_RISE: next_st.rdata = e0_rise;
        gpw_pkg::OFS_FALL: next_st.rdata = e0_fall;
        gpw_pkg::OFS_STAT: next_st.rdata = e0_stat;
        gpw_pkg::OFS_IMSK: next_st.rdata = e0_imsk;
        default: next_st.rdata = gpw_pkg::RD_UNMAPPED;
      endcase
    end
    if (i_bus_rd && edge2_hit) begin
      case (edge_ofs)
        gpw_pkg::OFS_RISE: next_st.rdata = e2_rise;
        gpw_pkg::OFS_FALL: next_st.rdata = e2_fall;
        gpw_pkg::OFS_STAT: next_st.rdata = e2_stat;
        gpw_pkg::OFS_IMSK: next_st.rdata = e2_imsk;
        default: next_st.rdata = gpw_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronous reset leaves every pin an input
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Edge units for port 0 and port 2
  // ----------------------------------------------------------------------
  // Port 0 edge detector
  gpw_edge u_edge0 (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin_sync(st.sync2[0]),
    .i_pin_raw(i_gpio_in[0]),
    .i_wr(i_bus_wr && edge0_hit),
    .i_ofs(edge_ofs),
    .i_wdata(i_bus_wdata),
    .i_be(i_bus_be),
    .o_rise_en(e0_rise),
    .o_fall_en(e0_fall),
    .o_stat(e0_stat),
    .o_imsk(e0_imsk),
    .o_irq(e0_irq),
    .o_wake(e0_wake)
  );

  // Port 2 edge detector
  gpw_edge u_edge2 (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin_sync(st.sync2[2]),
    .i_pin_raw(i_gpio_in[2]),
    .i_wr(i_bus_wr && edge2_hit),
    .i_ofs(edge_ofs),
    .i_wdata(i_bus_wdata),
    .i_be(i_bus_be),
    .o_rise_en(e2_rise),
    .o_fall_en(e2_fall),
    .o_stat(e2_stat),
    .o_imsk(e2_imsk),
    .o_irq(e2_irq),
    .o_wake(e2_wake)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Pins follow the latch and direction bits
  assign o_gpio_out = st.out;
  assign o_gpio_oe = st.dir;
  // Read data from a flop, zero-wait port for processor and DMA
  assign o_bus_rdata = st.rdata;
  // Level interrupt and wake request
  assign o_irq = e0_irq | e2_irq;
  assign o_wake = e0_wake | e2_wake;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // After reset no pin is driven
  a_reset_all_in: assert property (@(posedge i_sys_clk)
    $past(!i_rst_n) |-> (o_gpio_oe == '0))
    else $error("pin driven right after reset");

  // Direction write lands in the next cycle
  a_dir_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_DIR} && i_bus_be == 4'hF)
    |=> (o_gpio_oe[0] == $past(i_bus_wdata)))
    else $error("direction write lost");

  // Set register raises written unmasked bits
  a_set_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_SET} && i_bus_be == 4'hF)
    |=> ((o_gpio_out[0] & $past(i_bus_wdata) & ~$past(st.mask[0])) ==
         ($past(i_bus_wdata) & ~$past(st.mask[0]))))
    else $error("set write did not raise bits");

  // Clear write leaves every bit outside the written unmasked ones alone
  a_clr_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_CLR} && i_bus_be == 4'hF)
    |=> ((o_gpio_out[0] | ($past(i_bus_wdata) & ~$past(st.mask[0]))) ==
         ($past(o_gpio_out[0]) | ($past(i_bus_wdata) & ~$past(st.mask[0])))))
    else $error("clear write disturbed bits");

  // Latch readback appears exactly one cycle after the read
  a_out_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr == {3'h0, gpw_pkg::OFS_OUT}) |=> (o_bus_rdata == $past(st.out[0])))
    else $error("latch readback wrong");

  // Masked bits keep their value through a whole-port write
  a_mask_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h2, gpw_pkg::OFS_PIN})
    |=> ((o_gpio_out[2] & $past(st.mask[2])) == ($past(o_gpio_out[2]) & $past(st.mask[2]))))
    else $error("masked bit changed");

  // Byte write leaves the other lanes alone
  a_byte_lane: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h1, gpw_pkg::OFS_DIR} && i_bus_be == 4'h1)
    |=> (o_gpio_oe[1][31:8] == $past(o_gpio_oe[1][31:8])))
    else $error("byte write spilled into other lanes");

  // Full unmasked word write sets the whole port at once
  a_full_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_OUT} && i_bus_be == 4'hF &&
     st.mask[0] == '0) |=> (o_gpio_out[0] == $past(i_bus_wdata)))
    else $error("whole port write incomplete");

  // Pin level reaches the readable stage two cycles later
  a_pin_sync: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(i_rst_n) ##1 $past(i_rst_n) |-> (st.sync2 == $past(i_gpio_in, 2)))
    else $error("synchroniser delay wrong");

  // Read data stand only in the cycle after a read
  a_rdata_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_bus_rd) |=> (o_bus_rdata == '0))
    else $error("read data held too long");

  // Set write never lowers a bit that was already high
  a_set_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_SET})
    |=> ((o_gpio_out[0] & $past(o_gpio_out[0])) == $past(o_gpio_out[0])))
    else $error("set write lowered a bit");

  // Clear write never raises a bit that was low
  a_clr_keeps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h0, gpw_pkg::OFS_CLR})
    |=> ((o_gpio_out[0] & ~$past(o_gpio_out[0])) == '0))
    else $error("clear write raised a bit");

  // Direction readback follows the register
  a_dir_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr == {3'h1, gpw_pkg::OFS_DIR})
    |=> (o_bus_rdata == $past(o_gpio_oe[1])))
    else $error("direction readback wrong");

  // Live pin read shows synchronised levels, masked bits as zero
  a_pin_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr == {3'h2, gpw_pkg::OFS_PIN})
    |=> (o_bus_rdata == ($past(st.sync2[2]) & ~$past(st.mask[2]))))
    else $error("pin readback wrong");

  // Mask write lands whole in the next cycle
  a_mask_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_wr && i_bus_addr == {3'h2, gpw_pkg::OFS_MASK} && i_bus_be == 4'hF)
    |=> (st.mask[2] == $past(i_bus_wdata)))
    else $error("mask write lost");

  // Directions move only on a bus write
  a_dir_stable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_bus_wr) |=> $stable(o_gpio_oe))
    else $error("direction changed without a write");

  // Output latch moves only on a bus write
  a_out_stable: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_bus_wr) |=> $stable(o_gpio_out))
    else $error("output latch changed without a write");

  // Reads above the mapped windows return zero
  a_unmapped_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr[7]) |=> (o_bus_rdata == '0))
    else $error("unmapped read not zero");

  // Port 0 edge status readback
  a_stat0_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr == {gpw_pkg::EDGE0_BASE[7:4], gpw_pkg::OFS_STAT})
    |=> (o_bus_rdata == $past(e0_stat)))
    else $error("port 0 status readback wrong");

  // Port 2 edge status readback
  a_stat2_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_bus_rd && i_bus_addr == {gpw_pkg::EDGE2_BASE[7:4], gpw_pkg::OFS_STAT})
    |=> (o_bus_rdata == $past(e2_stat)))
    else $error("port 2 status readback wrong");

endmodule

/* testbench/gpw_board.sv */
// Board-side model of the external levels seen on the general purpose pins
module gpw_board (
  input wire logic [gpw_pkg::NUM_PORTS-1:0][31:0] i_gpio_out,
  input wire logic [gpw_pkg::NUM_PORTS-1:0][31:0] i_gpio_oe,
  input wire logic [gpw_pkg::NUM_PORTS-1:0][31:0] i_board_lvl,
  output logic [gpw_pkg::NUM_PORTS-1:0][31:0] o_gpio_in
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // A driven pin shows the port latch, an input pin shows the board level
  assign o_gpio_in = (i_gpio_oe & i_gpio_out) | (~i_gpio_oe & i_board_lvl);
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the general purpose port block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_sys_clk;
  logic i_rst_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic [2:0][31:0] gin;
  logic [2:0][31:0] gout;
  logic [2:0][31:0] goe;
  logic [2:0][31:0] board;  // Level the board puts on undriven pins
  logic irq;
  logic wake;
  int n_mismatch;
  int checked;
  logic [31:0] v;
  logic [31:0] r;
  logic [31:0] m;
  logic [31:0] e;
  logic [3:0] be_tab [4] = '{4'h3, 4'hc, 4'h1, 4'h8};  // Halfword and byte lanes
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  gpw_port u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus_addr(addr),
    .i_bus_wdata(wdata), .i_bus_be(be), .i_bus_wr(wr), .i_bus_rd(rd), .o_bus_rdata(rdata),
    .i_gpio_in(gin), .o_gpio_out(gout), .o_gpio_oe(goe), .o_irq(irq), .o_wake(wake));
  gpw_board u_board (.i_gpio_out(gout), .i_gpio_oe(goe), .i_board_lvl(board),
    .o_gpio_in(gin));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Clock at 100 ns period
  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // Byte address of a port register
  function automatic logic [7:0] pa(input int p, input logic [4:0] ofs);
    pa = 8'(p * 32) | {3'h0, ofs};
  endfunction
  // Bit mask of the enabled byte lanes
  function automatic logic [31:0] lanes(input logic [3:0] b);
    lanes = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) lanes[8*i +: 8] = 8'hff;
    end
  endfunction
  // One-cycle write strobe
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge i_sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    be <= b;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the following cycle
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_mismatch++;
    tally_and_finish;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    be = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    board = '0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(32'hcc50));
    repeat (6) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    // Every pin an input after reset, then random directions
    for (int p = 0; p < 3; p++) begin
      bus_rd(pa(p, gpw_pkg::OFS_DIR), r);
      check(r, 32'h0000_0000);
      check(goe[p], 32'h0000_0000);
      v = $urandom;
      bus_wr(pa(p, gpw_pkg::OFS_DIR), v, 4'hf);
      bus_rd(pa(p, gpw_pkg::OFS_DIR), r);
      check(r, v);
      check(goe[p], v);
    end
    // Partial-width writes touch only their lanes
    for (int i = 0; i < 4; i++) begin
      bus_rd(pa(1, gpw_pkg::OFS_DIR), e);
      v = $urandom;
      bus_wr(pa(1, gpw_pkg::OFS_DIR), v, be_tab[i]);
      bus_rd(pa(1, gpw_pkg::OFS_DIR), r);
      check(r, (e & ~lanes(be_tab[i])) | (v & lanes(be_tab[i])));
    end
    // Whole-port write, then set and clear on port 0
    e = $urandom;
    bus_wr(pa(0, gpw_pkg::OFS_OUT), e, 4'hf);
    #1 check(gout[0], e);
    v = $urandom;
    bus_wr(pa(0, gpw_pkg::OFS_SET), v, 4'hf);
    e = e | v;
    #1 check(gout[0], e);
    v = $urandom;
    bus_wr(pa(0, gpw_pkg::OFS_CLR), v, 4'hf);
    e = e & ~v;
    #1 check(gout[0], e);
    bus_rd(pa(0, gpw_pkg::OFS_OUT), r);
    check(r, e);
    // Masked group write and live pin read on port 2
    bus_wr(pa(2, gpw_pkg::OFS_OUT), 32'h0000_0000, 4'hf);
    m = $urandom;
    bus_wr(pa(2, gpw_pkg::OFS_MASK), m, 4'hf);
    v = $urandom;
    bus_wr(pa(2, gpw_pkg::OFS_PIN), v, 4'hf);
    e = v & ~m;
    #1 check(gout[2], e);
    bus_wr(pa(2, gpw_pkg::OFS_DIR), 32'h0000_ffff, 4'hf);
    board[2] <= $urandom | 32'h0010_0000;
    repeat (4) @(posedge i_sys_clk);
    bus_rd(pa(2, gpw_pkg::OFS_PIN), r);
    check(r, ((e & 32'h0000_ffff) | (board[2] & 32'hffff_0000)) & ~m);
    // Unmapped places read as zero
    bus_rd(8'h5c, r);
    check(r, 32'h0000_0000);
    bus_rd(8'h80, r);
    check(r, 32'h0000_0000);
    // Rising edge on port 0 bit 0 with interrupt enabled
    bus_wr(pa(0, gpw_pkg::OFS_DIR), 32'h0000_0000, 4'hf);
    repeat (4) @(posedge i_sys_clk);
    bus_wr(gpw_pkg::EDGE0_BASE + 8'h00, 32'h0000_0081, 4'hf);
    bus_wr(gpw_pkg::EDGE0_BASE + 8'h04, 32'h0000_0080, 4'hf);
    bus_wr(gpw_pkg::EDGE0_BASE + 8'h0c, 32'h0000_0001, 4'hf);
    @(posedge i_sys_clk);
    board[0][0] <= 1'b1;
    #1 check({31'h0, wake}, 32'h0000_0001);
    repeat (4) @(posedge i_sys_clk);
    bus_rd(gpw_pkg::EDGE0_BASE + 8'h08, r);
    check(r, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0001);
    repeat (10) @(posedge i_sys_clk);
    bus_rd(gpw_pkg::EDGE0_BASE + 8'h08, r);
    check(r, 32'h0000_0001);
    bus_wr(gpw_pkg::EDGE0_BASE + 8'h08, 32'h0000_0001, 4'hf);
    repeat (2) @(posedge i_sys_clk);
    check({31'h0, irq}, 32'h0000_0000);
    check({31'h0, wake}, 32'h0000_0000);
    // Both edges on bit 7, masked out of the interrupt
    for (int k = 0; k < 2; k++) begin
      @(posedge i_sys_clk);
      board[0][7] <= (k == 0);
      repeat (5) @(posedge i_sys_clk);
      bus_rd(gpw_pkg::EDGE0_BASE + 8'h08, r);
      check(r, 32'h0000_0080);
      check({31'h0, irq}, 32'h0000_0000);
      bus_wr(gpw_pkg::EDGE0_BASE + 8'h08, 32'h0000_0080, 4'hf);
    end
    // Falling edge on port 2 bit 20; a rise there is not enabled
    bus_wr(gpw_pkg::EDGE2_BASE + 8'h04, 32'h0010_0000, 4'hf);
    @(posedge i_sys_clk);
    board[2][20] <= 1'b0;
    repeat (5) @(posedge i_sys_clk);
    bus_rd(gpw_pkg::EDGE2_BASE + 8'h08, r);
    check(r, 32'h0010_0000);
    bus_wr(gpw_pkg::EDGE2_BASE + 8'h08, 32'h0010_0000, 4'hf);
    board[2][20] <= 1'b1;
    repeat (5) @(posedge i_sys_clk);
    bus_rd(gpw_pkg::EDGE2_BASE + 8'h08, r);
    check(r, 32'h0000_0000);
    tally_and_finish;
  end
endmodule
